//--- inc/ppc_pkg.sv
`default_nettype none
package ppc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_DATA = 8'h08; // data_port_latch
  localparam logic [7:0] IDX_DIR = 8'h88; // data_port_direction
  localparam logic [7:0] IDX_CTRL = 8'h89; // control_port_direction_status
  localparam logic [7:0] IDX_PINS = 8'h09; // control_port_pins
  localparam logic [7:0] IDX_ANALOG = 8'h9f; // analog_setup_reg
  localparam logic [7:0] IDX_IRQ_STAT = 8'h0c; // sticky event bits
  localparam logic [7:0] IDX_IRQ_MASK = 8'h8c; // event enables
  localparam int ADDR_W = 10; // index plus two byte bits
  // control_port_direction_status field positions
  localparam int CTRL_IN_FULL = 7; // input_buffer_full
  localparam int CTRL_OUT_FULL = 6; // output_buffer_full
  localparam int CTRL_OVF = 5; // input_overflow_flag
  localparam int CTRL_SEL = 4; // slave_port_select
  localparam int CTRL_DIR_W = 3; // direction bits 2:0
  // control pin roles in slave mode
  localparam int PIN_RD = 0; // read strobe, low active
  localparam int PIN_WR = 1; // write strobe, low active
  localparam int PIN_CS = 2; // chip select, low active
  // interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0; // slave_port_irq_flag
  localparam int IRQ_OVF = 1; // overflow event
  // reset values
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [2:0] CTRL_DIR_RST = 3'h7;
  localparam logic [2:0] ANALOG_RST = 3'h7; // all three analog
  localparam logic [7:0] DATA_RST = 8'h00;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx, 2'h0};
  endfunction : byte_addr
endpackage : ppc_pkg
`default_nettype wire

//--- logic/ppc_axil.sv
`timescale 1ns/100ps
`default_nettype none
// axi4-lite slave; turns bus beats into one-cycle register strobes
module ppc_axil (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ppc_pkg::ADDR_W-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [ppc_pkg::ADDR_W-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output logic reg_wr,
  output logic [ppc_pkg::ADDR_W-1:0] reg_waddr,
  output logic [7:0] reg_wdata,
  input wire logic wr_hit,
  output logic reg_rd,
  input wire logic [7:0] rd_val,
  input wire logic rd_hit
);
  logic aw_held; // address captured
  logic w_held; // data captured
  logic lane0; // low byte strobe of held data
  logic wr_fire; // both halves present, no response pending
  logic ar_fire; // read address taken

  assign s_axil_awready = ~aw_held;
  assign s_axil_wready = ~w_held;
  assign wr_fire = aw_held & w_held & ~s_axil_bvalid;
  // registers are one byte wide; other lanes carry nothing
  assign reg_wr = wr_fire & lane0 & wr_hit;
  assign s_axil_arready = ~s_axil_rvalid;
  assign ar_fire = s_axil_arvalid & s_axil_arready;
  assign reg_rd = ar_fire & rd_hit;

  // write channels accepted in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= ppc_pkg::RESP_OKAY;
      reg_waddr <= '0;
      reg_wdata <= 8'h00;
      lane0 <= 1'b0;
    end else begin
      if (s_axil_awvalid & ~aw_held) begin
        aw_held <= 1'b1;
        reg_waddr <= s_axil_awaddr;
      end
      if (s_axil_wvalid & ~w_held) begin
        w_held <= 1'b1;
        reg_wdata <= s_axil_wdata[7:0];
        lane0 <= s_axil_wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp <= wr_hit ? ppc_pkg::RESP_OKAY : ppc_pkg::RESP_SLVERR;
      end else if (s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end

  // read answered one edge after the address is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h0000_0000;
      s_axil_rresp <= ppc_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      s_axil_rvalid <= 1'b1;
      s_axil_rdata <= rd_hit ? {24'h00_0000, rd_val} : 32'h0000_0000;
      s_axil_rresp <= rd_hit ? ppc_pkg::RESP_OKAY : ppc_pkg::RESP_SLVERR;
    end else if (s_axil_rready) begin
      s_axil_rvalid <= 1'b0;
    end
  end
endmodule : ppc_axil
`default_nettype wire

//--- logic/ppc_host_cycle.sv
`timescale 1ns/100ps
`default_nettype none
// tracks host read and write cycles on the control pins
module ppc_host_cycle (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic cs_n,
  output logic wr_sel,
  output logic rd_sel,
  output logic wr_start,
  output logic wr_end,
  output logic rd_start,
  output logic rd_end
);
  typedef enum logic [1:0] {IDLE, WRITE, READ} ppc_host_state_t;
  ppc_host_state_t state; // current host cycle
  ppc_host_state_t next_state;

  // a cycle needs both strobe and select low
  assign wr_sel = en & ~wr_n & ~cs_n;
  assign rd_sel = en & ~rd_n & ~cs_n;
  // write checked first when both strobes low
  assign wr_start = (state == IDLE) & wr_sel;
  assign rd_start = (state == IDLE) & ~wr_sel & rd_sel;
  // level triggered end: either line high closes it
  assign wr_end = (state == WRITE) & ~wr_sel;
  assign rd_end = (state == READ) & ~rd_sel;

  // next state
  always_comb begin
    next_state = state;
    unique case (state)
      IDLE: begin
        if (wr_start) next_state = WRITE;
        else if (rd_start) next_state = READ;
      end
      WRITE: begin
        if (wr_end) next_state = IDLE;
      end
      READ: begin
        if (rd_end) next_state = IDLE;
      end
      default: next_state = IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) state <= IDLE;
    else state <= next_state;
  end
endmodule : ppc_host_cycle
`default_nettype wire

//--- logic/ppc_top.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R1 - data pins: gpio or host data bus bit
// R2 - each control pin has own direction bit
// R3 - slave select turns control pins into strobes
// R4 - firmware makes strobe pins digital inputs first
// R5 - analog control pin reads as zero
// R6 - direction bits drive pins even when analog
// R7 - reset makes control pins analog
// R8 - input full flag read-only, resets clear
// R9 - direction one input, zero output, resets one
// R10 - low read plus select reads data port
// R11 - low write plus select writes data port
// R12 - chip select is active low
// R13 - reset values of latch, direction, control
// R14 - write end sets full and irq flags
// R15 - second unread write sets overflow flag
// R16 - host read clears output full flag
// R17 - separate output and input latches in slave mode
// R18 - gpio direction one input, zero drives latch
// R19 - control bit 3 reads zero, ignores writes
module ppc_top #(
  parameter int DATA_W = 8, // data port width
  parameter int CTRL_W = ppc_pkg::CTRL_DIR_W // control pin count
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ppc_pkg::ADDR_W-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [ppc_pkg::ADDR_W-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic [DATA_W-1:0] data_pin_in,
  output logic [DATA_W-1:0] data_pin_out,
  output logic [DATA_W-1:0] data_pin_oe,
  input wire logic [CTRL_W-1:0] ctrl_pin_in,
  output logic [CTRL_W-1:0] ctrl_pin_out,
  output logic [CTRL_W-1:0] ctrl_pin_oe,
  output logic irq
);
  // address match against a register index
  function automatic logic hit(input logic [ppc_pkg::ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a == ppc_pkg::byte_addr(idx));
  endfunction : hit

  // register bus strobes
  logic reg_wr; // one-cycle write strobe
  logic [ppc_pkg::ADDR_W-1:0] reg_waddr; // held write address
  logic [7:0] reg_wdata; // held write byte
  logic reg_rd; // one-cycle read strobe
  logic wr_hit; // write address is mapped
  logic rd_hit; // read address is mapped
  logic [7:0] rd_val; // selected read byte

  // stored state
  logic [DATA_W-1:0] out_latch; // data_port_latch, cpu written
  logic [DATA_W-1:0] in_latch; // filled by host writes
  logic [DATA_W-1:0] dir; // data_port_direction
  logic [CTRL_W-1:0] ctrl_dir; // control pin directions
  logic slave_sel; // slave_port_select
  logic in_full; // input_buffer_full
  logic out_full; // output_buffer_full
  logic ovf; // input_overflow_flag
  logic [CTRL_W-1:0] pins_latch; // control_port_pins output latch
  logic [CTRL_W-1:0] analog; // analog_setup_reg, one = analog
  logic [ppc_pkg::IRQ_W-1:0] irq_stat; // sticky events
  logic [ppc_pkg::IRQ_W-1:0] irq_mask; // event enables

  // host cycle events
  logic host_wr_sel; // write cycle selected now
  logic host_rd_sel; // read cycle selected now
  logic host_wr_start;
  logic host_wr_end;
  logic host_rd_start;
  logic host_rd_end;

  // per-register write and read decode
  logic we_data, we_dir, we_ctrl, we_pins, we_analog, we_stat, we_mask;
  logic re_data;
  logic [ppc_pkg::IRQ_W-1:0] irq_set; // events this cycle
  logic [CTRL_W-1:0] pins_read; // control pins as software sees them
  logic [7:0] ctrl_read; // direction/status byte

  ppc_axil i_ppc_axil (
    .clk(clk),
    .rst(rst),
    .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready),
    .reg_wr(reg_wr),
    .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata),
    .wr_hit(wr_hit),
    .reg_rd(reg_rd),
    .rd_val(rd_val),
    .rd_hit(rd_hit)
  );

  // strobes and select only count in slave mode
  ppc_host_cycle i_ppc_host_cycle (
    .clk(clk),
    .rst(rst),
    .en(slave_sel), // R3
    .rd_n(ctrl_pin_in[ppc_pkg::PIN_RD]), // R10
    .wr_n(ctrl_pin_in[ppc_pkg::PIN_WR]), // R11
    .cs_n(ctrl_pin_in[ppc_pkg::PIN_CS]), // R12
    .wr_sel(host_wr_sel),
    .rd_sel(host_rd_sel),
    .wr_start(host_wr_start),
    .wr_end(host_wr_end),
    .rd_start(host_rd_start),
    .rd_end(host_rd_end)
  );

  // write decode
  assign we_data = reg_wr & hit(reg_waddr, ppc_pkg::IDX_DATA);
  assign we_dir = reg_wr & hit(reg_waddr, ppc_pkg::IDX_DIR);
  assign we_ctrl = reg_wr & hit(reg_waddr, ppc_pkg::IDX_CTRL);
  assign we_pins = reg_wr & hit(reg_waddr, ppc_pkg::IDX_PINS);
  assign we_analog = reg_wr & hit(reg_waddr, ppc_pkg::IDX_ANALOG);
  assign we_stat = reg_wr & hit(reg_waddr, ppc_pkg::IDX_IRQ_STAT);
  assign we_mask = reg_wr & hit(reg_waddr, ppc_pkg::IDX_IRQ_MASK);
  assign wr_hit = hit(reg_waddr, ppc_pkg::IDX_DATA)
                | hit(reg_waddr, ppc_pkg::IDX_DIR)
                | hit(reg_waddr, ppc_pkg::IDX_CTRL)
                | hit(reg_waddr, ppc_pkg::IDX_PINS)
                | hit(reg_waddr, ppc_pkg::IDX_ANALOG)
                | hit(reg_waddr, ppc_pkg::IDX_IRQ_STAT)
                | hit(reg_waddr, ppc_pkg::IDX_IRQ_MASK);

  // read decode; the data read has a side effect on in_full
  assign re_data = reg_rd & hit(s_axil_araddr, ppc_pkg::IDX_DATA);
  assign rd_hit = hit(s_axil_araddr, ppc_pkg::IDX_DATA)
                | hit(s_axil_araddr, ppc_pkg::IDX_DIR)
                | hit(s_axil_araddr, ppc_pkg::IDX_CTRL)
                | hit(s_axil_araddr, ppc_pkg::IDX_PINS)
                | hit(s_axil_araddr, ppc_pkg::IDX_ANALOG)
                | hit(s_axil_araddr, ppc_pkg::IDX_IRQ_STAT)
                | hit(s_axil_araddr, ppc_pkg::IDX_IRQ_MASK);

  // analog pins read zero whatever the pad does
  assign pins_read = ctrl_pin_in & ~analog; // R5
  // bit 3 is tied low, never stored
  assign ctrl_read = {in_full, out_full, ovf, slave_sel, 1'b0, ctrl_dir}; // R19

  // read mux; slave mode returns host-written byte, gpio the pads
  assign rd_val =
    hit(s_axil_araddr, ppc_pkg::IDX_DATA) ?
      (slave_sel ? in_latch : data_pin_in) : // R17
    hit(s_axil_araddr, ppc_pkg::IDX_DIR) ? dir :
    hit(s_axil_araddr, ppc_pkg::IDX_CTRL) ? ctrl_read :
    hit(s_axil_araddr, ppc_pkg::IDX_PINS) ? {5'h00, pins_read} :
    hit(s_axil_araddr, ppc_pkg::IDX_ANALOG) ? {5'h00, analog} :
    hit(s_axil_araddr, ppc_pkg::IDX_IRQ_STAT) ? {6'h00, irq_stat} :
    {6'h00, irq_mask};

  // data pins: host owns direction in slave mode, only while reading
  assign data_pin_oe = slave_sel ? {DATA_W{host_rd_sel}} : ~dir; // R1 R10 R18
  assign data_pin_out = out_latch; // R18
  // control drivers follow direction bits even when analog
  assign ctrl_pin_oe = ~ctrl_dir; // R2 R6 R9
  assign ctrl_pin_out = pins_latch;

  // event sources for the interrupt status
  assign irq_set[ppc_pkg::IRQ_DONE] = host_wr_end | host_rd_end; // R14
  assign irq_set[ppc_pkg::IRQ_OVF] = host_wr_start & in_full; // R15
  assign irq = |(irq_stat & irq_mask);

  // cpu output latch; kept apart from the host input latch
  always_ff @(posedge clk) begin
    if (rst) out_latch <= ppc_pkg::DATA_RST; // R13
    else if (we_data) out_latch <= reg_wdata; // R17
  end

  // host write byte captured every cycle of a selected write
  always_ff @(posedge clk) begin
    if (rst) in_latch <= ppc_pkg::DATA_RST;
    else if (host_wr_sel) in_latch <= data_pin_in; // R11
  end

  // direction registers
  always_ff @(posedge clk) begin
    if (rst) begin
      dir <= ppc_pkg::DIR_RST; // R13
      ctrl_dir <= ppc_pkg::CTRL_DIR_RST; // R9
    end else begin
      if (we_dir) dir <= reg_wdata;
      if (we_ctrl) ctrl_dir <= reg_wdata[CTRL_W-1:0]; // R2
    end
  end

  // mode select; firmware is trusted to set inputs and digital first
  always_ff @(posedge clk) begin
    if (rst) slave_sel <= 1'b0; // R13
    else if (we_ctrl) slave_sel <= reg_wdata[ppc_pkg::CTRL_SEL]; // R3 R4
  end

  // input full: set by host write end, cleared by cpu data read;
  // set wins so a byte landing during the read is not lost
  always_ff @(posedge clk) begin
    if (rst) in_full <= 1'b0; // R8
    else if (!slave_sel) in_full <= 1'b0;
    else if (host_wr_end) in_full <= 1'b1; // R14
    else if (re_data) in_full <= 1'b0; // R14
  end

  // output full: set by cpu write, cleared at host read start
  always_ff @(posedge clk) begin
    if (rst) out_full <= 1'b0;
    else if (!slave_sel) out_full <= 1'b0;
    else if (we_data) out_full <= 1'b1;
    else if (host_rd_start) out_full <= 1'b0; // R16
  end

  // overflow survives leaving slave mode; only firmware clears it
  always_ff @(posedge clk) begin
    if (rst) ovf <= 1'b0;
    else if (host_wr_start && in_full) ovf <= 1'b1; // R15
    else if (we_ctrl) ovf <= reg_wdata[ppc_pkg::CTRL_OVF];
  end

  // control pin output latch
  always_ff @(posedge clk) begin
    if (rst) pins_latch <= '0;
    else if (we_pins) pins_latch <= reg_wdata[CTRL_W-1:0];
  end

  // analog select; reset leaves all three pins analog
  always_ff @(posedge clk) begin
    if (rst) analog <= ppc_pkg::ANALOG_RST; // R7
    else if (we_analog) analog <= reg_wdata[CTRL_W-1:0];
  end

  // sticky status, write one to clear, a new event wins
  always_ff @(posedge clk) begin
    if (rst) irq_stat <= '0;
    else if (we_stat)
      irq_stat <= (irq_stat & ~reg_wdata[ppc_pkg::IRQ_W-1:0]) | irq_set;
    else irq_stat <= irq_stat | irq_set;
  end

  // interrupt enables
  always_ff @(posedge clk) begin
    if (rst) irq_mask <= '0;
    else if (we_mask) irq_mask <= reg_wdata[ppc_pkg::IRQ_W-1:0];
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // gpio mode: pad drivers follow inverted direction bits
  property p_gpio_dir;
    !slave_sel |-> (data_pin_oe == ~dir) && (data_pin_out == out_latch);
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) // R18
    else $error("gpio data pin enable does not follow direction");

  // slave mode: drive only while read and select low
  property p_host_drive;
    slave_sel && (|data_pin_oe) |->
      !ctrl_pin_in[ppc_pkg::PIN_RD] && !ctrl_pin_in[ppc_pkg::PIN_CS];
  endproperty
  a_host_drive: assert property (p_host_drive) // R10
    else $error("data pins driven outside a selected host read");

  // control drivers always from direction bits
  property p_ctrl_oe;
    ctrl_pin_oe == ~ctrl_dir;
  endproperty
  a_ctrl_oe: assert property (p_ctrl_oe) // R6
    else $error("control pin enable not from direction bits");

  // analog pin read returns zero one edge later
  property p_analog_zero;
    reg_rd && hit(s_axil_araddr, ppc_pkg::IDX_PINS) && analog[0]
      |=> s_axil_rvalid && !s_axil_rdata[0];
  endproperty
  a_analog_zero: assert property (p_analog_zero) // R5
    else $error("analog control pin did not read zero");

  // values seen on the first cycle after reset
  property p_reset_vals;
    $past(rst) |-> analog == ppc_pkg::ANALOG_RST && dir == ppc_pkg::DIR_RST
      && ctrl_read == {5'h00, ppc_pkg::CTRL_DIR_RST};
  endproperty
  a_reset_vals: assert property (p_reset_vals) // R13
    else $error("reset values wrong");

  // write end raises full flag and done event together
  property p_wr_end;
    host_wr_end && slave_sel |=> in_full && irq_stat[ppc_pkg::IRQ_DONE];
  endproperty
  a_wr_end: assert property (p_wr_end) // R14
    else $error("host write end did not set full and event flags");

  // unread byte overwritten raises overflow flag and its event
  // firmware may clear the flag at once, so only the next cycle is held
  property p_ovf;
    host_wr_start && in_full |=> ovf && irq_stat[ppc_pkg::IRQ_OVF];
  endproperty
  a_ovf: assert property (p_ovf) // R15
    else $error("overflow flag not set on second write");

  // host read start clears output full until next cpu write
  property p_out_full;
    host_rd_start && !we_data |=> !out_full;
  endproperty
  a_out_full: assert property (p_out_full) // R16
    else $error("output full flag not cleared by host read");

  // outside slave mode the full flags stay low
  property p_flags_idle;
    !slave_sel |=> !in_full && !out_full;
  endproperty
  a_flags_idle: assert property (p_flags_idle) // R8
    else $error("full flags set outside slave mode");

  // unimplemented bit never reads one
  property p_bit3;
    reg_rd && hit(s_axil_araddr, ppc_pkg::IDX_CTRL) |=> !s_axil_rdata[3];
  endproperty
  a_bit3: assert property (p_bit3) // R19
    else $error("unimplemented control bit read one");
endmodule : ppc_top
`default_nettype wire

//--- verif/ppc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// external 8-bit host: low active strobes and a byte bus
module ppc_host_model (
  input wire logic clk,
  input wire logic [7:0] bus,
  output logic rd_n,
  output logic wr_n,
  output logic cs_n,
  output logic [7:0] dq
);
  // idle: strobes high, chip not selected
  initial begin
    rd_n = 1'b1;
    wr_n = 1'b1;
    cs_n = 1'b1;
    dq = 8'h00;
  end

  // one host write; sel low keeps chip select high
  task automatic hwrite(input logic [7:0] d, input logic sel);
    @(posedge clk);
    dq <= d;
    cs_n <= ~sel;
    wr_n <= 1'b0;
    // random strobe length: prompt or slow host
    repeat (1 + $urandom % 4) @(posedge clk);
    wr_n <= 1'b1;
    cs_n <= 1'b1;
    @(posedge clk);
    // released bus has no pull: show inverse of last byte
    dq <= ~d;
    // deselected gap before the next cycle
    @(posedge clk);
  endtask : hwrite

  // one host read; byte taken while still selected
  task automatic hread(output logic [7:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (2 + $urandom % 3) @(posedge clk);
    d = bus;
    rd_n <= 1'b1;
    cs_n <= 1'b1;
    @(posedge clk);
  endtask : hread
endmodule : ppc_host_model
`default_nettype wire

//--- verif/parallel_port_pin_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
// bench: bus master, host model, queued result checks
module parallel_port_pin_control_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  // bus master side, driven after rising edges
  logic [ppc_pkg::ADDR_W-1:0] awaddr = '0;
  logic [ppc_pkg::ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf; // whole words only
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  // block answers
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  // pads: resolved level, block drive, host drive
  logic [7:0] dpin_in, dpin_out, dpin_oe, host_dq;
  logic [2:0] cpin_in, cpin_out, cpin_oe;
  logic host_rd_n, host_wr_n, host_cs_n;
  // expectation notes and counters
  logic [33:0] rq[$]; // {rresp, rdata}
  logic [1:0] bq[$]; // bresp
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [7:0] w1, w2, hd;

  // 100 MHz clock
  always #5 clk = ~clk;

  // wire level: block drives where enabled, host elsewhere
  assign dpin_in = (dpin_oe & dpin_out) | (~dpin_oe & host_dq);
  assign cpin_in = (cpin_oe & cpin_out) |
    (~cpin_oe & {host_cs_n, host_wr_n, host_rd_n});

  ppc_top i_ppc_top (
    .clk(clk), .rst(rst), .s_axil_awaddr(awaddr),
    .s_axil_awvalid(awvalid), .s_axil_awready(awready),
    .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
    .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
    .s_axil_bready(bready), .s_axil_araddr(araddr),
    .s_axil_arvalid(arvalid), .s_axil_arready(arready),
    .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
    .s_axil_rready(rready), .data_pin_in(dpin_in),
    .data_pin_out(dpin_out), .data_pin_oe(dpin_oe),
    .ctrl_pin_in(cpin_in), .ctrl_pin_out(cpin_out),
    .ctrl_pin_oe(cpin_oe), .irq(irq)
  );
  ppc_host_model i_ppc_host_model (
    .clk(clk), .bus(dpin_in), .rd_n(host_rd_n), .wr_n(host_wr_n),
    .cs_n(host_cs_n), .dq(host_dq)
  );

  // compare one result; unknowns never match
  task automatic chk(input string nm, input logic [33:0] e,
      input logic [33:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // counts, verdict, end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // an expired wait counts as a mismatch and ends the run
  task automatic hang(input string nm);
    n_mismatch++;
    $display("Error %s expected answer seen none", nm);
    final_report();
  endtask : hang

  // register write; each channel released once taken
  task automatic axw(input logic [7:0] idx, input logic [7:0] d,
      input logic [1:0] er = ppc_pkg::RESP_OKAY);
    logic ad, wd, bd;
    int n;
    ad = 1'b0;
    wd = 1'b0;
    bd = 1'b0;
    bq.push_back(er);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40 && !bd; n++) begin
      @(posedge clk);
      ad = ad | awready;
      wd = wd | wready;
      bd = bvalid;
      awvalid <= ~ad;
      wvalid <= ~wd;
      bready <= ~bd;
    end
    if (!bd) hang("bvalid");
    // idle edge so bready is not driven twice in one step
    @(posedge clk);
  endtask : axw

  // register read; expected word noted for the watcher
  task automatic axr(input logic [7:0] idx, input logic [7:0] d,
      input logic [1:0] er = ppc_pkg::RESP_OKAY);
    logic ad, rd;
    int n;
    ad = 1'b0;
    rd = 1'b0;
    rq.push_back({er, 24'h0, d});
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40 && !rd; n++) begin
      @(posedge clk);
      ad = ad | arready;
      rd = rvalid;
      arvalid <= ~ad;
      rready <= ~rd;
    end
    if (!rd) hang("rvalid");
    @(posedge clk);
  endtask : axr

  // watcher: each bus answer against the oldest note
  always @(posedge clk) begin
    if (rvalid && rready && rq.size() > 0) begin
      chk("rdata", rq.pop_front(), {rresp, rdata});
    end
    if (bvalid && bready && bq.size() > 0) begin
      chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
    end
  end

  // main sequence
  initial begin
    void'($urandom(32'h073908cf));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    axr(ppc_pkg::IDX_DIR, 8'hff);
    axr(ppc_pkg::IDX_CTRL, 8'h07);
    axr(ppc_pkg::IDX_PINS, 8'h00);
    chk("ctrl_oe", 34'h0, {31'h0, cpin_oe});
    axr(8'hff, 8'h00, ppc_pkg::RESP_SLVERR);
    axw(8'hff, 8'h5a, ppc_pkg::RESP_SLVERR);
    $display("test reset done");
    // bit 3 ignored; pins 0 and 2 outputs while still analog
    axw(ppc_pkg::IDX_CTRL, 8'h0a);
    axr(ppc_pkg::IDX_CTRL, 8'h02);
    chk("ctrl_oe", 34'h5, {31'h0, cpin_oe});
    axw(ppc_pkg::IDX_PINS, 8'h01);
    chk("ctrl_out", 34'h1, {31'h0, cpin_out});
    axr(ppc_pkg::IDX_PINS, 8'h00);
    axw(ppc_pkg::IDX_ANALOG, 8'h00);
    axr(ppc_pkg::IDX_PINS, 8'h03);
    // general data port: low nibble input
    w1 = 8'($urandom);
    axw(ppc_pkg::IDX_DIR, 8'h0f);
    axw(ppc_pkg::IDX_DATA, w1);
    chk("data_oe", 34'hf0, {26'h0, dpin_oe});
    chk("data_out", {26'h0, w1}, {26'h0, dpin_out});
    $display("test general io done");
    // slave mode: strobe pins inputs and digital
    axw(ppc_pkg::IDX_CTRL, 8'h17);
    axw(ppc_pkg::IDX_IRQ_MASK, 8'h03);
    axr(ppc_pkg::IDX_CTRL, 8'h17);
    w1 = 8'($urandom);
    w2 = 8'($urandom);
    i_ppc_host_model.hwrite(w1, 1'b1);
    axr(ppc_pkg::IDX_CTRL, 8'h97);
    chk("irq", 34'h1, {33'h0, irq});
    i_ppc_host_model.hwrite(w2, 1'b1);
    axr(ppc_pkg::IDX_CTRL, 8'hb7);
    axr(ppc_pkg::IDX_DATA, w2);
    axr(ppc_pkg::IDX_CTRL, 8'h37);
    axw(ppc_pkg::IDX_CTRL, 8'h17);
    axr(ppc_pkg::IDX_CTRL, 8'h17);
    // write strobe without chip select is no write
    i_ppc_host_model.hwrite(~w2, 1'b0);
    axr(ppc_pkg::IDX_CTRL, 8'h17);
    axw(ppc_pkg::IDX_DATA, 8'h3c);
    axr(ppc_pkg::IDX_CTRL, 8'h57);
    i_ppc_host_model.hread(hd);
    chk("host_rd", 34'h3c, {26'h0, hd});
    axr(ppc_pkg::IDX_CTRL, 8'h17);
    // full flags are read-only: writing ones leaves them clear
    axw(ppc_pkg::IDX_CTRL, 8'hd7);
    axr(ppc_pkg::IDX_CTRL, 8'h17);
    $display("test slave port done");
    // interrupt: status, mask, one-to-clear
    axr(ppc_pkg::IDX_IRQ_STAT, 8'h03);
    axw(ppc_pkg::IDX_IRQ_MASK, 8'h00);
    chk("irq", 34'h0, {33'h0, irq});
    axw(ppc_pkg::IDX_IRQ_MASK, 8'h03);
    chk("irq", 34'h1, {33'h0, irq});
    axw(ppc_pkg::IDX_IRQ_STAT, 8'h03);
    chk("irq", 34'h0, {33'h0, irq});
    $display("test interrupt done");
    final_report();
  end
endmodule : parallel_port_pin_control_bench
`default_nettype wire
